// >>> lower_port_command_rx_error_flags.sv
`timescale 1ns/1ps
module lower_port_command_rx_error_flags #(
    parameter int ADR_W = 16
) (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   rst_b,
    // classic wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [ADR_W-1:0]       wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    // received bytes from the lower chain port
    input  wire rx_err_pkg::rx_byte_t   rx_byte,
    // bytes forwarded up the stack
    output logic                        fwd_valid,
    output logic      [7:0]             fwd_data,
    // frame counter events
    output rx_err_pkg::frame_evt_t      frame_evt,
    // interrupt
    output logic                        irq
);

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic [ADR_W-3:0] word_idx;
    logic             bus_req;
    logic             bus_wr;
    logic             hit_status;
    logic             hit_mask;
    logic             hit_ctrl;

    assign word_idx = wb_adr_i[ADR_W-1:2];
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];

    always_comb begin
        hit_status = 1'b0;
        hit_mask   = 1'b0;
        hit_ctrl   = 1'b0;
        if (word_idx == rx_err_pkg::STATUS_IDX[ADR_W-3:0]) begin
            hit_status = 1'b1;
        end else if (word_idx == rx_err_pkg::MASK_IDX[ADR_W-3:0]) begin
            hit_mask = 1'b1;
        end else if (word_idx == rx_err_pkg::CTRL_IDX[ADR_W-3:0]) begin
            hit_ctrl = 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [7:0]  status_reg;
    logic [7:0]  status_next;
    logic [7:0]  mask_reg;
    logic [7:0]  mask_next;
    logic [1:0]  ctrl_reg;
    logic [1:0]  ctrl_next;
    logic        ack_reg;
    logic        ack_next;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic [7:0]  set_bits;
    logic [7:0]  clr_bits;
    logic        dir_sel;
    logic        lower_tx_en;

    assign dir_sel     = ctrl_reg[rx_err_pkg::CTRL_DIR];
    assign lower_tx_en = ctrl_reg[rx_err_pkg::CTRL_TX_EN];

    always_comb begin
        clr_bits = (bus_wr && hit_status) ? wb_dat_i[7:0] : 8'h00;
        // hardware set wins over a software clear
        status_next = ((status_reg & ~clr_bits) | set_bits) & rx_err_pkg::STATUS_USED;
        mask_next   = (bus_wr && hit_mask) ? wb_dat_i[7:0] : mask_reg;
        ctrl_next   = (bus_wr && hit_ctrl) ? wb_dat_i[1:0] : ctrl_reg;
        ack_next    = bus_req;
        rdat_next   = rdat_reg;
        if (bus_req && !wb_we_i) begin
            if (hit_status) begin
                rdat_next = {24'h000000, status_reg};
            end else if (hit_mask) begin
                rdat_next = {24'h000000, mask_reg};
            end else if (hit_ctrl) begin
                rdat_next = {30'h0, ctrl_reg};
            end else begin
                rdat_next = 32'h00000000;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            status_reg <= rx_err_pkg::STATUS_RST;
            mask_reg   <= rx_err_pkg::MASK_RST;
            ctrl_reg   <= rx_err_pkg::CTRL_RST;
            ack_reg    <= 1'b0;
            rdat_reg   <= 32'h00000000;
        end else begin
            status_reg <= status_next;
            mask_reg   <= mask_next;
            ctrl_reg   <= ctrl_next;
            ack_reg    <= ack_next;
            rdat_reg   <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign irq      = |(status_reg & mask_reg);

    // ---------------------------------------------------------------
    // frame parser
    // ---------------------------------------------------------------
    rx_err_pkg::rx_state_t  state_reg;
    rx_err_pkg::rx_state_t  state_next;
    logic                   bad_reg;
    logic                   bad_next;
    logic                   fwd_valid_reg;
    logic                   fwd_valid_next;
    logic [7:0]             fwd_data_reg;
    logic [7:0]             fwd_data_next;
    rx_err_pkg::frame_evt_t evt_reg;
    rx_err_pkg::frame_evt_t evt_next;
    logic                   sof;
    logic [2:0]             ftype;
    logic                   type_ok;
    logic                   is_read;

    assign sof   = rx_byte.data[rx_err_pkg::SOF_BIT];
    assign ftype = rx_byte.data[rx_err_pkg::TYPE_MSB:rx_err_pkg::TYPE_LSB];

    always_comb begin
        type_ok = (ftype == rx_err_pkg::TYPE_SINGLE_RD) || (ftype == rx_err_pkg::TYPE_SINGLE_WR)
               || (ftype == rx_err_pkg::TYPE_STACK_RD)  || (ftype == rx_err_pkg::TYPE_STACK_WR)
               || (ftype == rx_err_pkg::TYPE_BCAST_RD)  || (ftype == rx_err_pkg::TYPE_BCAST_WR);
        is_read = (ftype == rx_err_pkg::TYPE_SINGLE_RD) || (ftype == rx_err_pkg::TYPE_STACK_RD)
               || (ftype == rx_err_pkg::TYPE_BCAST_RD);
    end

    always_comb begin
        state_next     = state_reg;
        bad_next       = bad_reg;
        set_bits       = 8'h00;
        evt_next       = '0;
        // every byte is passed up regardless of its checks
        fwd_valid_next = rx_byte.valid;
        fwd_data_next  = rx_byte.valid ? rx_byte.data : fwd_data_reg;
        if (rx_byte.valid) begin
            case (state_reg)
                rx_err_pkg::ST_INIT,
                rx_err_pkg::ST_IGNORE: begin
                    if (state_reg == rx_err_pkg::ST_IGNORE && !sof) begin
                        // no checks, no counting while ignoring
                        state_next = rx_err_pkg::ST_IGNORE;
                    end else if (!sof) begin
                        set_bits[rx_err_pkg::BIT_INIT] = 1'b1;
                        state_next = rx_err_pkg::ST_IGNORE;
                    end else if (!type_ok) begin
                        set_bits[rx_err_pkg::BIT_INIT] = 1'b1;
                        state_next = rx_err_pkg::ST_IGNORE;
                    end else begin
                        bad_next = rx_byte.byte_err;
                        set_bits[rx_err_pkg::BIT_BYTE] = rx_byte.byte_err;
                        if (dir_sel) begin
                            set_bits[rx_err_pkg::BIT_UNEXP] = 1'b1;
                            bad_next = 1'b1;
                        end else if (is_read && !lower_tx_en) begin
                            set_bits[rx_err_pkg::BIT_TXDIS] = 1'b1;
                            bad_next = 1'b1;
                        end
                        if (rx_byte.last) begin
                            evt_next.discard_frame = 1'b1;
                            state_next = rx_err_pkg::ST_INIT;
                        end else begin
                            state_next = rx_err_pkg::ST_BODY;
                        end
                    end
                end
                rx_err_pkg::ST_BODY: begin
                    if (sof) begin
                        // new frame start inside a frame: drop the old one
                        set_bits[rx_err_pkg::BIT_SOF] = 1'b1;
                        evt_next.discard_frame = 1'b1;
                        bad_next   = 1'b0;
                        state_next = rx_err_pkg::ST_INIT;
                    end else begin
                        set_bits[rx_err_pkg::BIT_BYTE] = rx_byte.byte_err;
                        if (rx_byte.last) begin
                            set_bits[rx_err_pkg::BIT_CRC] = rx_byte.crc_err;
                            if (bad_reg || rx_byte.byte_err || rx_byte.crc_err) begin
                                evt_next.discard_frame = 1'b1;
                            end else begin
                                evt_next.valid_frame = 1'b1;
                            end
                            bad_next   = 1'b0;
                            state_next = rx_err_pkg::ST_INIT;
                        end else begin
                            bad_next = bad_reg || rx_byte.byte_err;
                        end
                    end
                end
                default: begin
                    state_next = rx_err_pkg::ST_INIT;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            state_reg     <= rx_err_pkg::ST_INIT;
            bad_reg       <= 1'b0;
            fwd_valid_reg <= 1'b0;
            fwd_data_reg  <= 8'h00;
            evt_reg       <= '0;
        end else begin
            state_reg     <= state_next;
            bad_reg       <= bad_next;
            fwd_valid_reg <= fwd_valid_next;
            fwd_data_reg  <= fwd_data_next;
            evt_reg       <= evt_next;
        end
    end

    assign fwd_valid = fwd_valid_reg;
    assign fwd_data  = fwd_data_reg;
    assign frame_evt = evt_reg;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    property p_init_nosof;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg == rx_err_pkg::ST_INIT && !sof)
            |=> status_reg[rx_err_pkg::BIT_INIT] && state_reg == rx_err_pkg::ST_IGNORE;
    endproperty
    a_init_nosof: assert property (p_init_nosof) else $error("init error not flagged");

    property p_init_type;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg != rx_err_pkg::ST_BODY && sof && !type_ok)
            |=> status_reg[rx_err_pkg::BIT_INIT];
    endproperty
    a_init_type: assert property (p_init_type) else $error("bad type not flagged");

    property p_forward;
        @(posedge core_clk) disable iff (!rst_b)
        rx_byte.valid |=> fwd_valid && fwd_data == $past(rx_byte.data);
    endproperty
    a_forward: assert property (p_forward) else $error("byte not forwarded");

    property p_ignore_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == rx_err_pkg::ST_IGNORE && rx_byte.valid && !sof)
            |=> state_reg == rx_err_pkg::ST_IGNORE;
    endproperty
    a_ignore_hold: assert property (p_ignore_hold) else $error("left ignore without sof");

    property p_ignore_quiet;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == rx_err_pkg::ST_IGNORE && rx_byte.valid && !sof)
            |-> set_bits == 8'h00 ##1 frame_evt == '0;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored frame checked");

    property p_txdis;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg != rx_err_pkg::ST_BODY && sof && type_ok && is_read
         && !dir_sel && !lower_tx_en)
            |=> status_reg[rx_err_pkg::BIT_TXDIS];
    endproperty
    a_txdis: assert property (p_txdis) else $error("tx disabled read not flagged");

    property p_txdis_discard;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg == rx_err_pkg::ST_BODY && !sof && rx_byte.last && bad_reg)
            |=> frame_evt.discard_frame && !frame_evt.valid_frame;
    endproperty
    a_txdis_discard: assert property (p_txdis_discard) else $error("bad frame not discarded");

    property p_read_back;
        @(posedge core_clk) disable iff (!rst_b)
        (bus_req && !wb_we_i && hit_status)
            |=> wb_ack_o && wb_dat_o[7:0] == $past(status_reg) && wb_dat_o[31:8] == 24'h000000;
    endproperty
    a_read_back: assert property (p_read_back) else $error("status read mismatch");

    property p_unexp;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg != rx_err_pkg::ST_BODY && sof && type_ok && dir_sel)
            |=> status_reg[rx_err_pkg::BIT_UNEXP];
    endproperty
    a_unexp: assert property (p_unexp) else $error("unexpected command not flagged");

    property p_reserved;
        @(posedge core_clk) disable iff (!rst_b)
        wb_ack_o && $past(hit_status) && !$past(wb_we_i) |-> wb_dat_o[7:6] == 2'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_mid_sof;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg == rx_err_pkg::ST_BODY && sof)
            |=> status_reg[rx_err_pkg::BIT_SOF] && frame_evt.discard_frame
                && state_reg == rx_err_pkg::ST_INIT;
    endproperty
    a_mid_sof: assert property (p_mid_sof) else $error("sof error missed");

    property p_crc_flag;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg == rx_err_pkg::ST_BODY && !sof && rx_byte.last
         && rx_byte.crc_err)
            |=> status_reg[rx_err_pkg::BIT_CRC] && frame_evt.discard_frame;
    endproperty
    a_crc_flag: assert property (p_crc_flag) else $error("crc error missed");

    property p_sticky;
        @(posedge core_clk) disable iff (!rst_b)
        !(bus_wr && hit_status) |=> (status_reg & $past(status_reg)) == $past(status_reg);
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost without clear");

    property p_ignore_exit;
        @(posedge core_clk) disable iff (!rst_b)
        (state_reg == rx_err_pkg::ST_IGNORE && rx_byte.valid && sof && type_ok)
            |=> state_reg != rx_err_pkg::ST_IGNORE;
    endproperty
    a_ignore_exit: assert property (p_ignore_exit) else $error("ignore not ended");

    property p_txdis_dir;
        @(posedge core_clk) disable iff (!rst_b)
        (rx_byte.valid && state_reg != rx_err_pkg::ST_BODY && sof && type_ok && dir_sel
         && !(bus_wr && hit_status))
            |=> status_reg[rx_err_pkg::BIT_TXDIS] == $past(status_reg[rx_err_pkg::BIT_TXDIS]);
    endproperty
    a_txdis_dir: assert property (p_txdis_dir) else $error("txdis with dir 1");

endmodule

// >>> rx_err_pkg.sv
package rx_err_pkg;

    // ---------------------------------------------------------------
    // register map (word index, byte address is four times the index)
    // ---------------------------------------------------------------
    localparam logic [15:0] STATUS_IDX  = 16'h0787;
    localparam logic [15:0] MASK_IDX    = 16'h0790;
    localparam logic [15:0] CTRL_IDX    = 16'h0791;
    localparam logic [7:0]  STATUS_RST  = 8'h00;
    localparam logic [7:0]  MASK_RST    = 8'h00;
    localparam logic [1:0]  CTRL_RST    = 2'h0;

    // ---------------------------------------------------------------
    // status bit positions
    // ---------------------------------------------------------------
    localparam int BIT_INIT  = 5;
    localparam int BIT_TXDIS = 4;
    localparam int BIT_SOF   = 3;
    localparam int BIT_BYTE  = 2;
    localparam int BIT_UNEXP = 1;
    localparam int BIT_CRC   = 0;
    localparam logic [7:0] STATUS_USED = 8'h3f;

    // ctrl bit positions
    localparam int CTRL_DIR   = 0;
    localparam int CTRL_TX_EN = 1;

    // ---------------------------------------------------------------
    // initialization byte layout and frame type codes
    // ---------------------------------------------------------------
    localparam int SOF_BIT  = 7;
    localparam int TYPE_MSB = 6;
    localparam int TYPE_LSB = 4;
    localparam logic [2:0] TYPE_SINGLE_RD = 3'h0;
    localparam logic [2:0] TYPE_SINGLE_WR = 3'h1;
    localparam logic [2:0] TYPE_STACK_RD  = 3'h2;
    localparam logic [2:0] TYPE_STACK_WR  = 3'h3;
    localparam logic [2:0] TYPE_BCAST_RD  = 3'h4;
    localparam logic [2:0] TYPE_BCAST_WR  = 3'h5;

    // one received byte from the lower chain port
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       last;
        logic       byte_err;
        logic       crc_err;
    } rx_byte_t;

    // frame classification towards the frame counters
    typedef struct packed {
        logic valid_frame;
        logic discard_frame;
    } frame_evt_t;

    typedef enum logic [1:0] {
        ST_INIT,
        ST_BODY,
        ST_IGNORE
    } rx_state_t;

endpackage

// >>> chain_neighbor.sv
`timescale 1ns/1ps
// -------------------------------------------------------------------
// adjacent stacked device driving the lower chain port
// -------------------------------------------------------------------
module chain_neighbor (
    // clock
    input  wire logic            core_clk,
    // byte link towards the block
    output rx_err_pkg::rx_byte_t rx_byte
);
    logic [7:0] last_data;

    initial begin
        rx_byte   = '0;
        last_data = 8'h00;
    end

    // one byte per edge, back to back allowed
    task automatic send(input logic [7:0] d, input logic l, input logic be, input logic ce);
        @(posedge core_clk);
        rx_byte   <= '{valid: 1'b1, data: d, last: l, byte_err: be, crc_err: ce};
        last_data = d;
    endtask

    // released line shows no stale byte
    task automatic release_line();
        @(posedge core_clk);
        rx_byte <= '{valid: 1'b0, data: ~last_data, last: 1'b0, byte_err: 1'b0, crc_err: 1'b0};
    endtask
endmodule

// >>> tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_count++; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb;
    localparam logic [15:0] A_ST = 16'(rx_err_pkg::STATUS_IDX << 2);
    localparam logic [15:0] A_MK = 16'(rx_err_pkg::MASK_IDX << 2);
    localparam logic [15:0] A_CT = 16'(rx_err_pkg::CTRL_IDX << 2);
    logic                      core_clk;
    logic                      rst_b;
    logic                      wb_cyc_i;
    logic                      wb_stb_i;
    logic                      wb_we_i;
    logic [15:0]               wb_adr_i;
    logic [3:0]                wb_sel_i;
    logic [31:0]               wb_dat_i;
    logic [31:0]               wb_dat_o;
    logic                      wb_ack_o;
    rx_err_pkg::rx_byte_t      rx_byte;
    logic                      fwd_valid;
    logic [7:0]                fwd_data;
    rx_err_pkg::frame_evt_t    frame_evt;
    logic                      irq;
    int                        err_count;
    int                        compares;
    logic [31:0]               q_rd[$];
    logic [7:0]                q_fwd[$];
    rx_err_pkg::frame_evt_t    q_evt[$];
    logic [31:0]               e32;
    logic [7:0]                e8;
    rx_err_pkg::frame_evt_t    e2;

    chain_neighbor i_nb (.core_clk(core_clk), .rx_byte(rx_byte));

    lower_port_command_rx_error_flags #(.ADR_W(16)) i_dut (
        .core_clk(core_clk), .rst_b(rst_b),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .rx_byte(rx_byte), .fwd_valid(fwd_valid), .fwd_data(fwd_data),
        .frame_evt(frame_evt), .irq(irq)
    );

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // -------------------------------------------------------------------
    // closing report
    // -------------------------------------------------------------------
    task automatic end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // -------------------------------------------------------------------
    // wishbone master and byte stimulus
    // -------------------------------------------------------------------
    task automatic wb(input logic we, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            err_count++;
            $display("mismatch wb_ack expected 1 seen 0");
            end_of_test();
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        wb(1'b1, a, d, 4'h1);
    endtask

    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        wb(1'b0, a, 32'h0, 4'hf);
    endtask

    task automatic chk_irq(input logic e);
        @(negedge core_clk);
        `CHK("irq", e, irq)
    endtask

    task automatic tx(input logic [7:0] d, input logic l, input logic be, input logic ce);
        q_fwd.push_back(d);
        i_nb.send(d, l, be, ce);
    endtask

    // init byte, body byte, final byte
    task automatic frame(input logic [7:0] ini, input logic [1:0] evt, input logic be,
                         input logic ce);
        int unsigned r;
        r = $urandom;
        if (evt != 2'b00)
            q_evt.push_back(rx_err_pkg::frame_evt_t'(evt));
        tx(ini, 1'b0, 1'b0, 1'b0);
        tx({1'b0, r[6:0]}, 1'b0, be, 1'b0);
        tx({1'b0, r[14:8]}, 1'b1, 1'b0, ce);
        i_nb.release_line();
    endtask

    // -------------------------------------------------------------------
    // result watcher
    // -------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (rst_b === 1'b1) begin
            if (fwd_valid === 1'b1) begin
                e8 = q_fwd.size() > 0 ? q_fwd.pop_front() : ~fwd_data;
                `CHK("fwd_data", e8, fwd_data)
            end
            if (frame_evt !== 2'b00) begin
                e2 = q_evt.size() > 0 ? q_evt.pop_front() : 2'b00;
                `CHK("frame_evt", e2, frame_evt)
            end
            if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
                e32 = q_rd.size() > 0 ? q_rd.pop_front() : ~wb_dat_o;
                `CHK("wb_dat_o", e32, wb_dat_o)
            end
        end
    end

    // -------------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------------
    initial begin
        int          t;
        int unsigned r;
        err_count = 0;
        compares  = 0;
        rst_b     = 1'b0;
        wb_cyc_i  = 1'b0;
        wb_stb_i  = 1'b0;
        wb_we_i   = 1'b0;
        wb_adr_i  = 16'h0000;
        wb_sel_i  = 4'h0;
        wb_dat_i  = 32'h0;
        void'($urandom(26403));
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(A_ST, 32'h0);
        rd(A_MK, 32'h0);
        rd(A_CT, 32'h0);
        wr(16'h0004, 32'hff);
        rd(16'h0004, 32'h0);
        wr(A_CT, 32'h2);
        rd(A_CT, 32'h2);
        for (t = 0; t < 6; t++)
            frame({1'b1, t[2:0], 4'h0}, 2'b10, 1'b0, 1'b0);
        rd(A_ST, 32'h0);
        for (t = 0; t < 3; t++) begin
            wr(A_MK, 32'h20);
            frame(t == 2 ? 8'h10 : {1'b1, 3'h6 + t[2:0], 4'h0}, 2'b00, 1'b1, 1'b1);
            rd(A_ST, 32'h20);
            chk_irq(1'b1);
            wr(A_MK, 32'h0);
            chk_irq(1'b0);
            wr(A_ST, 32'h20);
            rd(A_ST, 32'h0);
            frame(8'h90, 2'b10, 1'b0, 1'b0);
        end
        wr(A_CT, 32'h0);
        for (t = 0; t < 6; t += 2) begin
            frame({1'b1, t[2:0], 4'h0}, 2'b01, 1'b0, 1'b0);
            rd(A_ST, 32'h10);
            wr(A_ST, 32'h10);
        end
        frame(8'h90, 2'b10, 1'b0, 1'b0);
        rd(A_ST, 32'h0);
        wr(A_CT, 32'h3);
        frame(8'h90, 2'b01, 1'b0, 1'b0);
        rd(A_ST, 32'h2);
        wr(A_ST, 32'h2);
        wr(A_CT, 32'h2);
        frame(8'h90, 2'b01, 1'b1, 1'b0);
        rd(A_ST, 32'h4);
        wr(A_ST, 32'h4);
        frame(8'h90, 2'b01, 1'b0, 1'b1);
        rd(A_ST, 32'h1);
        wr(A_ST, 32'h1);
        // init byte that is also the final byte counts as discard
        q_evt.push_back(rx_err_pkg::frame_evt_t'(2'b01));
        tx(8'h92, 1'b1, 1'b0, 1'b0);
        i_nb.release_line();
        rd(A_ST, 32'h0);
        q_evt.push_back(rx_err_pkg::frame_evt_t'(2'b01));
        tx(8'h90, 1'b0, 1'b0, 1'b0);
        tx(8'h05, 1'b0, 1'b0, 1'b0);
        tx(8'h90, 1'b0, 1'b0, 1'b0);
        frame(8'h90, 2'b10, 1'b0, 1'b0);
        rd(A_ST, 32'h8);
        wb(1'b1, A_ST, 32'h8, 4'he);
        rd(A_ST, 32'h8);
        wr(A_ST, 32'h8);
        rd(A_ST, 32'h0);
        r = $urandom;
        wr(A_MK, {24'h0, r[7:0]});
        rd(A_MK, {24'h0, r[7:0]});
        for (t = 0; t < 20 && (q_rd.size() + q_fwd.size() + q_evt.size()) > 0; t++)
            @(posedge core_clk);
        `CHK("pending", 0, q_rd.size() + q_fwd.size() + q_evt.size())
        end_of_test();
    end
endmodule
